// File: design/rics_io_compare_switch_unit.sv
// io compare switch unit: merges two lockstep cpu buses onto one io bus and checks them
// assumes both cpus are on clk; io bus returns read data combinationally; alarm and supply pins are async
`timescale 1ns/1ps
module rics_io_compare_switch_unit #(
  parameter int RATE_WINDOW = rics_pkg::RATE_WINDOW_CYC,  // alarm observation window in cycles
  parameter int RATE_LIMIT  = rics_pkg::RATE_LIMIT        // alarms allowed per window
) (
  input  wire logic                        clk,             // 100 MHz system clock
  input  wire logic                        arst_n,          // async reset, active low
  input  wire logic                        cpu1_strobe,     // cpu one cycle request
  input  wire logic [rics_pkg::ADDR_W-1:0] cpu1_addr,       // cpu one address
  input  wire logic [rics_pkg::DATA_W-1:0] cpu1_wdata,      // cpu one write data
  input  wire logic [rics_pkg::CTRL_W-1:0] cpu1_ctrl,       // cpu one control lines
  input  wire logic                        cpu2_strobe,     // cpu two cycle request
  input  wire logic [rics_pkg::ADDR_W-1:0] cpu2_addr,       // cpu two address
  input  wire logic [rics_pkg::DATA_W-1:0] cpu2_wdata,      // cpu two write data
  input  wire logic [rics_pkg::CTRL_W-1:0] cpu2_ctrl,       // cpu two control lines
  output logic      [rics_pkg::DATA_W-1:0] cpu1_rdata,      // read data to cpu one
  output logic      [rics_pkg::DATA_W-1:0] cpu2_rdata,      // read data to cpu two
  output logic                             cpu1_ack,        // cycle done to cpu one
  output logic                             cpu2_ack,        // cycle done to cpu two
  output logic                             compare_error,   // sticky mismatch to cpus
  output logic                             io_strobe,       // single io bus cycle
  output logic      [rics_pkg::ADDR_W-1:0] io_addr,         // io bus address
  output logic      [rics_pkg::DATA_W-1:0] io_wdata,        // io bus write data
  output logic      [rics_pkg::CTRL_W-1:0] io_ctrl,         // io bus control lines
  input  wire logic [rics_pkg::DATA_W-1:0] io_rdata,        // io bus read data
  input  wire logic [7:0]                  jumper,          // jumper straps
  input  wire logic                        supply24_ok,     // 24 V rail in tolerance
  input  wire logic                        supply5_ok,      // 5 V rail in tolerance
  input  wire logic [rics_pkg::ALARM_N-1:0] alarm_a,        // process_alarm_line set a
  input  wire logic [rics_pkg::ALARM_N-1:0] alarm_b,        // process_alarm_line set b
  input  wire logic [rics_pkg::ALARM_N-1:0] alarm_c,        // process_alarm_line set c
  output logic                             master_sel,      // mastership selection
  output logic                             check_pulse,     // start local unit check
  output logic                             supply_fault,    // supply out of tolerance
  output logic                             alarm_irq,       // alarm interrupt request
  output logic                             alarm_inhibit    // interrupts blocked by rate
);
  // ==========================================================================
  // functions
  // ==========================================================================
  function automatic rics_pkg::rics_range_e decode_range(input logic [rics_pkg::ADDR_W-1:0] a);
    if (a <= rics_pkg::IO_HI_ADDR) begin
      decode_range = rics_pkg::RICS_RANGE_IO;
    end else if (a == rics_pkg::ALARM_ADDR) begin
      decode_range = rics_pkg::RICS_RANGE_ALARM;
    end else if (a >= rics_pkg::REG_JUMPER && a <= rics_pkg::REG_ALARM_HI) begin
      decode_range = rics_pkg::RICS_RANGE_REG;
    end else begin
      decode_range = rics_pkg::RICS_RANGE_NONE;
    end
  endfunction : decode_range

  // ==========================================================================
  // input synchronisers for pins
  // ==========================================================================
  // each alarm set is synchronised on its own, so the merge only ever reads settled bits
  logic [1:0]                                   sup_s1, sup_s2;
  logic [7:0]                                   jmp_s1, jmp_s2;
  logic [rics_pkg::SRC_N*rics_pkg::ALARM_N-1:0] al_raw1, al_raw2;
  logic [rics_pkg::ALARM_N-1:0]                 al_s2;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sup_s1  <= 2'h3;
      sup_s2  <= 2'h3;
      jmp_s1  <= 8'h00;
      jmp_s2  <= 8'h00;
      al_raw1 <= '0;
      al_raw2 <= '0;
    end else begin
      sup_s1  <= {supply24_ok, supply5_ok};
      sup_s2  <= sup_s1;
      jmp_s1  <= jumper;
      jmp_s2  <= jmp_s1;
      al_raw1 <= {alarm_c, alarm_b, alarm_a};
      al_raw2 <= al_raw1;
    end
  end
  // redundant sources on one position fold into one logical bit, never more than 48
  assign al_s2 = al_raw2[47:0] | al_raw2[95:48] | al_raw2[143:96];

  // ==========================================================================
  // channel compare and merge
  // ==========================================================================
  logic                        mismatch;
  logic                        cyc;
  logic                        is_wr;
  rics_pkg::rics_range_e       range;
  logic [rics_pkg::DATA_W-1:0] rd_word;
  always_comb begin
    // the ack path is also compared so a broken fan-out shows up
    mismatch = (cpu1_strobe != cpu2_strobe) || (cpu1_strobe && ((cpu1_addr != cpu2_addr) ||
               (cpu1_wdata != cpu2_wdata) || (cpu1_ctrl != cpu2_ctrl))) ||
               (cpu1_rdata != cpu2_rdata) || (cpu1_ack != cpu2_ack);
    cyc   = cpu1_strobe && cpu2_strobe;
    is_wr = cpu1_ctrl[rics_pkg::CW_WRITE_BIT];
    range = decode_range(cpu1_addr);
    io_strobe = cyc && (range == rics_pkg::RICS_RANGE_IO) && !mismatch;
    io_addr   = cpu1_addr;
    io_wdata  = cpu1_wdata;
    io_ctrl   = cpu1_ctrl;
  end

  // ==========================================================================
  // register state
  // ==========================================================================
  logic [rics_pkg::ADDR_W-1:0] last_io, next_last_io, last_reg, next_last_reg;
  logic [rics_pkg::DATA_W-1:0] cmp_word, next_cmp_word;
  logic                        next_error, next_master, next_check;
  logic [rics_pkg::DATA_W-1:0] next_rdata;
  logic                        next_ack, clear_req;
  logic [rics_pkg::ALARM_N-1:0] alarm_prev, alarm_rise;
  logic [31:0]                 win_cnt, next_win_cnt;
  logic [15:0]                 rate_cnt, next_rate_cnt;
  logic                        next_inhibit, next_irq, next_supply_fault;

  always_comb begin
    clear_req = cyc && !mismatch && is_wr && cpu1_addr == rics_pkg::REG_CONTROL &&
                cpu1_wdata[rics_pkg::CTL_CLEAR_BIT];
    rd_word = rics_pkg::DATA_RST;
    if (range == rics_pkg::RICS_RANGE_IO) begin
      rd_word = io_rdata;
    end else if (range == rics_pkg::RICS_RANGE_ALARM || cpu1_addr == rics_pkg::REG_ALARM_LO) begin
      rd_word = al_s2[15:0];
    end else if (cpu1_addr == rics_pkg::REG_ALARM_MID) begin
      rd_word = al_s2[31:16];
    end else if (cpu1_addr == rics_pkg::REG_ALARM_HI) begin
      rd_word = al_s2[47:32];
    end else if (cpu1_addr == rics_pkg::REG_JUMPER) begin
      rd_word = {8'h00, jmp_s2};
    end else if (cpu1_addr == rics_pkg::REG_LAST_IO) begin
      rd_word = {8'h00, last_io};
    end else if (cpu1_addr == rics_pkg::REG_LAST_REG) begin
      rd_word = {8'h00, last_reg};
    end else if (cpu1_addr == rics_pkg::REG_COMPARE) begin
      rd_word = cmp_word;
    end else if (cpu1_addr == rics_pkg::REG_STATUS) begin
      rd_word = {11'h000, alarm_inhibit, supply_fault, compare_error, master_sel, 1'b0};
    end
    next_rdata = cyc ? rd_word : rics_pkg::DATA_RST;
    next_ack   = cyc;
    next_last_io  = io_strobe ? cpu1_addr : last_io;
    next_last_reg = (cyc && range != rics_pkg::RICS_RANGE_IO) ? cpu1_addr : last_reg;
    // set wins over clear so a mismatch in the clearing cycle is kept
    next_error    = mismatch ? 1'b1 : (clear_req ? 1'b0 : compare_error);
    next_cmp_word = mismatch ? {cpu1_addr ^ cpu2_addr, 4'h0, cpu1_ctrl ^ cpu2_ctrl} :
                    (clear_req ? rics_pkg::DATA_RST : cmp_word);
    next_master = master_sel;
    next_check  = 1'b0;
    if (cyc && !mismatch && is_wr && cpu1_addr == rics_pkg::REG_CONTROL) begin
      next_master = cpu1_wdata[rics_pkg::CTL_MASTER_BIT];
      next_check  = cpu1_wdata[rics_pkg::CTL_CHECK_BIT];
    end
    // alarm rate window: count cycles with a rising alarm, inhibit past the limit
    alarm_rise    = al_s2 & ~alarm_prev;
    next_win_cnt  = (win_cnt >= 32'(RATE_WINDOW - 1)) ? 32'h0 : win_cnt + 32'h1;
    next_rate_cnt = (win_cnt >= 32'(RATE_WINDOW - 1)) ? 16'h0 :
                    ((|alarm_rise && rate_cnt != 16'hffff) ? rate_cnt + 16'h1 : rate_cnt);
    next_inhibit  = alarm_inhibit;
    if (rate_cnt > 16'(RATE_LIMIT)) begin
      next_inhibit = 1'b1;
    end else if (clear_req) begin
      next_inhibit = 1'b0;
    end
    // one inhibit blocks every alarm passing this unit
    next_irq = |al_s2 && !next_inhibit;
    next_supply_fault = ~&sup_s2;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_io       <= '0;
      last_reg      <= '0;
      cmp_word      <= rics_pkg::DATA_RST;
      compare_error <= 1'b0;
      master_sel    <= rics_pkg::MASTER_RST;
      check_pulse   <= 1'b0;
      cpu1_rdata    <= rics_pkg::DATA_RST;
      cpu2_rdata    <= rics_pkg::DATA_RST;
      cpu1_ack      <= 1'b0;
      cpu2_ack      <= 1'b0;
      alarm_prev    <= '0;
      win_cnt       <= '0;
      rate_cnt      <= '0;
      alarm_inhibit <= 1'b0;
      alarm_irq     <= 1'b0;
      supply_fault  <= 1'b0;
    end else begin
      last_io       <= next_last_io;
      last_reg      <= next_last_reg;
      cmp_word      <= next_cmp_word;
      compare_error <= next_error;
      master_sel    <= next_master;
      check_pulse   <= next_check;
      cpu1_rdata    <= next_rdata;
      cpu2_rdata    <= next_rdata;
      cpu1_ack      <= next_ack;
      cpu2_ack      <= next_ack;
      alarm_prev    <= al_s2;
      win_cnt       <= next_win_cnt;
      rate_cnt      <= next_rate_cnt;
      alarm_inhibit <= next_inhibit;
      alarm_irq     <= next_irq;
      supply_fault  <= next_supply_fault;
    end
  end
endmodule : rics_io_compare_switch_unit

// File: design/rics_pkg.sv
// package for the redundant io compare switch: widths, address map, control fields, reset and timing constants
// assumes a single 100 MHz clock domain shared with the lockstep cpus
package rics_pkg;
  // ==========================================================================
  // widths
  // ==========================================================================
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 16;
  localparam int CTRL_W   = 4;
  localparam int ALARM_N  = 48;
  localparam int SRC_N    = 3;
  // ==========================================================================
  // address map: ordinary io range and group alarm word just above it
  // ==========================================================================
  localparam logic [ADDR_W-1:0] IO_LO_ADDR    = 8'h00;
  localparam logic [ADDR_W-1:0] IO_HI_ADDR    = 8'h60;
  localparam logic [ADDR_W-1:0] ALARM_ADDR    = 8'h61;
  // internal registers sit above the group alarm word
  localparam logic [ADDR_W-1:0] REG_JUMPER    = 8'h70;
  localparam logic [ADDR_W-1:0] REG_LAST_IO   = 8'h71;
  localparam logic [ADDR_W-1:0] REG_LAST_REG  = 8'h72;
  localparam logic [ADDR_W-1:0] REG_COMPARE   = 8'h73;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h74;
  localparam logic [ADDR_W-1:0] REG_CONTROL   = 8'h75;
  localparam logic [ADDR_W-1:0] REG_ALARM_LO  = 8'h76;
  localparam logic [ADDR_W-1:0] REG_ALARM_MID = 8'h77;
  localparam logic [ADDR_W-1:0] REG_ALARM_HI  = 8'h78;
  // ==========================================================================
  // control register fields
  // ==========================================================================
  localparam int CTL_MASTER_BIT = 0;
  localparam int CTL_CHECK_BIT  = 1;
  localparam int CTL_CLEAR_BIT  = 2;
  // control word bits: 0 write, 1 read
  localparam int CW_WRITE_BIT   = 0;
  localparam int CW_READ_BIT    = 1;
  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic              MASTER_RST = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RST   = 16'h0000;
  // ==========================================================================
  // alarm rate limit defaults
  // ==========================================================================
  localparam int RATE_WINDOW_US = 1000;
  localparam int CLK_MHZ        = 100;
  localparam int RATE_WINDOW_CYC = RATE_WINDOW_US * CLK_MHZ;
  localparam int RATE_LIMIT     = 16;
  // ==========================================================================
  // address range decode result
  // ==========================================================================
  typedef enum logic [1:0] {
    RICS_RANGE_IO    = 2'b00,
    RICS_RANGE_ALARM = 2'b01,
    RICS_RANGE_REG   = 2'b10,
    RICS_RANGE_NONE  = 2'b11
  } rics_range_e;
endpackage : rics_pkg

// File: verif/rics_chk_properties.sv
// checker for the io compare switch unit: cycle merge, compare, supply and alarm gating
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module rics_chk_properties (
  input wire logic        clk,           // clock
  input wire logic        arst_n,        // reset
  input wire logic        cpu1_strobe,   // cpu one
  input wire logic        cpu2_strobe,   // cpu two
  input wire logic [7:0]  cpu1_addr,     // cpu one
  input wire logic [7:0]  cpu2_addr,     // cpu two
  input wire logic [15:0] cpu1_wdata,    // cpu one
  input wire logic [15:0] cpu2_wdata,    // cpu two
  input wire logic [3:0]  cpu1_ctrl,     // cpu one
  input wire logic [3:0]  cpu2_ctrl,     // cpu two
  input wire logic        cpu1_ack,      // cpu one
  input wire logic        cpu2_ack,      // cpu two
  input wire logic [15:0] cpu1_rdata,    // cpu one
  input wire logic [15:0] cpu2_rdata,    // cpu two
  input wire logic        compare_error, // sticky error
  input wire logic        io_strobe,     // io cycle
  input wire logic [7:0]  io_addr,       // io address
  input wire logic        supply24_ok,   // rail
  input wire logic        supply5_ok,    // rail
  input wire logic        supply_fault,  // rail fault
  input wire logic        check_pulse,   // check start
  input wire logic        alarm_irq,     // alarm request
  input wire logic        alarm_inhibit  // rate inhibit
);
  // ==========================================================================
  // helpers
  // ==========================================================================
  wire take  = cpu1_strobe && cpu2_strobe;
  wire same  = cpu1_addr == cpu2_addr && cpu1_wdata == cpu2_wdata && cpu1_ctrl == cpu2_ctrl;
  wire ctlwr = take && same && cpu1_addr == rics_pkg::REG_CONTROL && cpu1_ctrl[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_mismatch; take && !same; endsequence
  sequence s_clear; ctlwr && cpu1_wdata[2]; endsequence
  // ==========================================================================
  // properties
  // ==========================================================================
  a_ack_pair: assert property (take |=> cpu1_ack && cpu2_ack)
    else $error("ack missing after a taken cycle");
  a_ack_cause: assert property (cpu1_ack |-> $past(take))
    else $error("ack without a taken cycle");
  a_fanout_same: assert property (cpu1_rdata == cpu2_rdata && cpu1_ack == cpu2_ack)
    else $error("cpu answers differ");
  a_io_decode: assert property (io_strobe |-> take && same && cpu1_addr <= rics_pkg::IO_HI_ADDR)
    else $error("io cycle outside range or unmatched");
  a_io_copy: assert property (io_strobe |-> io_addr == cpu1_addr)
    else $error("io address not copied");
  a_err_set: assert property (s_mismatch |=> compare_error)
    else $error("mismatch not flagged");
  a_err_hold: assert property (compare_error && !ctlwr |=> compare_error)
    else $error("error dropped without clear");
  a_err_clear: assert property (s_clear ##1 !$past(!same && take) |-> !compare_error)
    else $error("clear write ignored");
  a_check_src: assert property (check_pulse |-> $past(ctlwr && cpu1_wdata[1]))
    else $error("check pulse without control write");
  a_supply_bad: assert property ((!supply24_ok || !supply5_ok) [*5] |-> supply_fault)
    else $error("supply fault missing");
  a_irq_gate: assert property (alarm_inhibit && $past(alarm_inhibit) |-> !alarm_irq)
    else $error("alarm request while inhibited");
endmodule : rics_chk_properties

bind rics_io_compare_switch_unit rics_chk_properties u_chk (.*);

// File: verif/rics_io_model.sv
// io module model on the single-channel bus: keeps writes, answers reads in the strobe cycle
// assumes the unit holds its io lines for the whole strobe cycle
`timescale 1ns/1ps
module rics_io_model (
  input  wire logic [0:0]  clk,       // clock
  input  wire logic        io_strobe, // io cycle
  input  wire logic [7:0]  io_addr,   // address
  input  wire logic [15:0] io_wdata,  // write data
  input  wire logic [3:0]  io_ctrl,   // bit0 write, bit1 read
  output logic      [15:0] io_rdata   // read data
);
  logic [15:0] mem [256];
  logic [15:0] last = 16'h0000;
  initial foreach (mem[i]) mem[i] = 16'h0000;
  // an idle bus shows the inverse of the last value so a stale sample cannot pass
  assign io_rdata = (io_strobe && io_ctrl[1]) ? mem[io_addr] : ~last;
  always @(posedge clk) begin
    if (io_strobe && io_ctrl[0]) mem[io_addr] <= io_wdata;
    if (io_strobe) last <= io_rdata;
  end
endmodule : rics_io_model

// File: verif/tb.sv
// self-checking bench for the io compare switch unit with an io module model behind it
// assumes short rate parameters so the chatter scenario fits in a few hundred cycles
`timescale 1ns/1ps
module tb;
  localparam int WIN = 64;
  localparam int LIM = 2;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        s1, s2, k1, k2, err, ios, s24, s5, msel, cpulse, sfault, irq, inh, io_seen, cp;
  logic [7:0]  a1, a2, ioa, jmp;
  logic [15:0] w1, w2, r1, r2, iow, iord, rd;
  logic [3:0]  c1, c2, ioc;
  logic [47:0] al_a, al_b, al_c;
  logic [15:0] mem [int];
  logic [7:0]  io_list [3] = '{8'h00, 8'h05, 8'h60};
  int          fails = 0;
  int          cmp_count = 0;
  int          seed = 95;
  always #5 clk = ~clk;
  rics_io_compare_switch_unit #(.RATE_WINDOW(WIN), .RATE_LIMIT(LIM)) dut (.clk(clk), .arst_n(arst_n),
    .cpu1_strobe(s1), .cpu1_addr(a1), .cpu1_wdata(w1), .cpu1_ctrl(c1), .cpu2_strobe(s2), .cpu2_addr(a2),
    .cpu2_wdata(w2), .cpu2_ctrl(c2), .cpu1_rdata(r1), .cpu2_rdata(r2), .cpu1_ack(k1), .cpu2_ack(k2),
    .compare_error(err), .io_strobe(ios), .io_addr(ioa), .io_wdata(iow), .io_ctrl(ioc), .io_rdata(iord),
    .jumper(jmp), .supply24_ok(s24), .supply5_ok(s5), .alarm_a(al_a), .alarm_b(al_b), .alarm_c(al_c),
    .master_sel(msel), .check_pulse(cpulse), .supply_fault(sfault), .alarm_irq(irq), .alarm_inhibit(inh));
  rics_io_model io (.clk(clk), .io_strobe(ios), .io_addr(ioa), .io_wdata(iow), .io_ctrl(ioc), .io_rdata(iord));
  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  // one duplicated cycle; bad flips an address bit on the second cpu only
  task automatic cyc(input logic [7:0] a, input logic [15:0] w, input logic [3:0] c, input logic bad);
    @(posedge clk);
    #1;
    {s1, s2, a1, a2, w1, w2, c1, c2} = {2'b11, a, a ^ {7'h00, bad}, w, w, c, c};
    #1;
    io_seen = ios;
    @(posedge clk);
    #1;
    {cp, rd} = {cpulse, r1};
    {s1, s2} = 2'b00;
    chk(k1 & k2, 1'b1);
    chk(r2, r1);
  endtask : cyc
  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    final_report();
  end
  initial begin
    {s1, s2, a1, a2, w1, w2, c1, c2, al_a, al_b, al_c} = '0;
    {s24, s5} = 2'b11;
    jmp = 8'($random(seed));
    wt(6);
    arst_n = 1'b1;
    chk(msel, rics_pkg::MASTER_RST);
    chk(err, 1'b0);
    foreach (io_list[i]) begin
      mem[io_list[i]] = 16'($random(seed));
      cyc(io_list[i], mem[io_list[i]], 4'h1, 1'b0);
      chk(io_seen, 1'b1);
      cyc(io_list[i], 16'h0000, 4'h2, 1'b0);
      chk(rd, mem[io_list[i]]);
    end
    cyc(8'h90, 16'h0000, 4'h2, 1'b0);
    chk(io_seen, 1'b0);
    chk(rd, 16'h0000);
    {al_a[3], al_c[3], al_b[40]} = 3'b111;
    wt(4);
    chk(irq, 1'b1);
    cyc(rics_pkg::ALARM_ADDR, 16'h0000, 4'h2, 1'b0);
    chk(rd, 16'h0008);
    cyc(rics_pkg::REG_ALARM_HI, 16'h0000, 4'h2, 1'b0);
    chk(rd, 16'h0100);
    cyc(rics_pkg::REG_ALARM_MID, 16'h0000, 4'h2, 1'b0);
    chk(rd, 16'h0000);
    cyc(rics_pkg::REG_JUMPER, 16'h0000, 4'h2, 1'b0);
    chk(rd, {8'h00, jmp});
    cyc(8'h05, 16'h0000, 4'h2, 1'b1);
    chk(io_seen, 1'b0);
    chk(err, 1'b1);
    cyc(rics_pkg::REG_STATUS, 16'h0000, 4'h2, 1'b0);
    chk(rd, 16'h0004);
    cyc(rics_pkg::REG_COMPARE, 16'h0000, 4'h2, 1'b0);
    chk(rd, 16'h0100);
    cyc(rics_pkg::REG_LAST_IO, 16'h0000, 4'h2, 1'b0);
    chk(rd, {8'h00, io_list[2]});
    cyc(rics_pkg::REG_LAST_REG, 16'h0000, 4'h2, 1'b0);
    chk(rd, {8'h00, rics_pkg::REG_LAST_IO});
    cyc(rics_pkg::REG_CONTROL, 16'h0007, 4'h1, 1'b0);
    chk({cp, msel, err}, 3'b110);
    cyc(rics_pkg::REG_CONTROL, 16'h0000, 4'h1, 1'b0);
    chk({cp, msel}, 2'b00);
    for (int i = 0; i < 2; i++) begin
      {s24, s5} = i ? 2'b10 : 2'b01;
      // five bad samples so the checker's supply window is reached
      wt(5);
      chk(sfault, 1'b1);
      {s24, s5} = 2'b11;
      wt(4);
      chk(sfault, 1'b0);
    end
    // chattering line: enough rising edges that a window boundary cannot split them under the limit
    {al_a, al_b, al_c} = '0;
    wt(WIN * 2);
    repeat (2 * LIM + 1) begin
      al_b[7] = 1'b1;
      wt(3);
      al_b[7] = 1'b0;
      wt(3);
    end
    {al_b[7], al_a[20]} = 2'b11;
    wt(4);
    chk(inh, 1'b1);
    chk(irq, 1'b0);
    {al_a, al_b, al_c} = '0;
    wt(WIN * 2);
    cyc(rics_pkg::REG_CONTROL, 16'h0004, 4'h1, 1'b0);
    chk(inh, 1'b0);
    al_c[47] = 1'b1;
    wt(4);
    chk(irq, 1'b1);
    final_report();
  end
endmodule : tb
